// File: hdl/tcf_pkg.sv
/*
 * tcf_pkg: constants, register map and carrier types of the trigger
 * conditioning filter.
 * assumes: one 40 MHz core clock; avalon-mm byte addresses, 32-bit data.
 */
package tcf_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int HOLD_UNIT_NS = 15;
    localparam int HOLD_COUNT_RST = 66666;
    localparam int ACT_MIN_NS = 25605;
    localparam int ACT_MAX_NS = 50130;
    localparam int ACT_MIN_CYC = (ACT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACT_MAX_CYC = ACT_MAX_NS / CLK_PERIOD_NS;
    localparam int ACT_CNT_W = 11;
    localparam int ELAPSED_W = 37;

    // ************************************************************
    // register map (byte offsets)
    // ************************************************************
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_HOLD = 5'h04;
    localparam logic [4:0] REG_DIV = 5'h08;
    localparam logic [4:0] REG_DEV_KEY = 5'h0C;
    localparam logic [4:0] REG_GRP_KEY = 5'h10;
    localparam logic [4:0] REG_GRP_MASK = 5'h14;
    localparam logic [4:0] REG_STATUS = 5'h18;
    localparam logic [4:0] REG_TRIG_CNT = 5'h1C;

    localparam int CTRL_DEB_EN = 0;
    localparam int CTRL_ACT_EN = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [3:0] DIV_RST = 4'h0;
    localparam logic [31:0] KEY_RST = 32'h0000_0000;

    localparam int STAT_RAW = 0;
    localparam int STAT_FILT = 1;
    localparam int STAT_PEND = 2;
    localparam int STAT_PCNT_LSB = 4;

    // ************************************************************
    // action packet layout
    // ************************************************************
    localparam logic [7:0] PKT_KEY = 8'h42;
    localparam logic [7:0] PKT_FLAG_ACK = 8'h01;
    localparam logic [7:0] PKT_FLAG_NOACK = 8'h00;
    localparam logic [15:0] PKT_CMD_ACTION = 16'h0100;
    localparam logic [15:0] PKT_UDP_PORT = 16'd3956;
    localparam logic [4:0] PKT_IDX_FLAG = 5'd1;
    localparam logic [4:0] PKT_IDX_CMD = 5'd3;
    localparam logic [4:0] PKT_IDX_REQ = 5'd7;
    localparam logic [4:0] PKT_IDX_DEV = 5'd11;
    localparam logic [4:0] PKT_IDX_GRP = 5'd15;
    localparam logic [4:0] PKT_IDX_LAST = 5'd19;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic for_me;
        logic bcast;
        logic [15:0] udp_port;
        logic [7:0] data;
    } tcf_pkt_t;

    typedef struct packed {
        logic valid;
        logic [15:0] req_id;
    } tcf_ack_t;

    typedef enum logic [1:0] {
        PS_IDLE,
        PS_BODY,
        PS_DROP
    } tcf_pstate_t;

endpackage

// File: hdl/tcf_trigger_filter.sv
/*
 * tcf_trigger_filter: debouncer, prescaler and network action-packet
 * trigger source with an avalon-mm register slave.
 * assumes: raw trigger and packet bytes are synchronous to core_clk; the
 * mac delivers udp payload bytes with sop/eop and its address verdict.
 */
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps

module tcf_trigger_filter
    import tcf_pkg::*;
#(
    parameter int HOLD_DEFAULT = HOLD_COUNT_RST
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic raw_trigger_in,
    input wire tcf_pkt_t pkt_in,
    output logic trigger_out,
    output tcf_ack_t ack_out
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [1:0] ctrl_r;
    logic [31:0] debounce_hold_count_r;
    logic [3:0] div_r;
    logic [31:0] device_auth_key_r;
    logic [31:0] group_select_key_r;
    logic [31:0] group_filter_mask_r;
    logic [31:0] trig_cnt_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic wr_take;
    logic rd_go;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // one wait cycle per access; the write lands on the edge that sees
    // waitrequest low, matching when the master releases it
    assign wr_take = avs_write && !wait_r;
    assign rd_go = avs_read && wait_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_r <= 1'b1;
        end else if ((avs_read || avs_write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= CTRL_RST;
            debounce_hold_count_r <= 32'(HOLD_DEFAULT);
            div_r <= DIV_RST;
            device_auth_key_r <= KEY_RST;
            group_select_key_r <= KEY_RST;
            group_filter_mask_r <= KEY_RST;
        end else if (wr_take) begin
            unique case ({avs_address[4:2], 2'b00})
                REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        ctrl_r <= avs_writedata[1:0];
                    end
                end
                REG_HOLD: begin
                    debounce_hold_count_r <= be_merge(debounce_hold_count_r,
                                                      avs_writedata, avs_byteenable);
                end
                REG_DIV: begin
                    if (avs_byteenable[0]) begin
                        div_r <= avs_writedata[3:0];
                    end
                end
                REG_DEV_KEY: begin
                    device_auth_key_r <= be_merge(device_auth_key_r,
                                                  avs_writedata, avs_byteenable);
                end
                REG_GRP_KEY: begin
                    group_select_key_r <= be_merge(group_select_key_r,
                                                   avs_writedata, avs_byteenable);
                end
                REG_GRP_MASK: begin
                    group_filter_mask_r <= be_merge(group_filter_mask_r,
                                                    avs_writedata, avs_byteenable);
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // debouncer
    // ************************************************************
    logic raw_prev_r;
    logic stable_r;
    logic stable_prev_r;
    logic [ELAPSED_W-1:0] elapsed_r;
    logic [ELAPSED_W-1:0] hold_ns;
    logic [ELAPSED_W-1:0] elapsed_nxt;

    // hold is in 15 ns units but the clock ticks in 25 ns, so the
    // stable time is tracked in ns and the acceptance rounds up
    assign hold_ns = ELAPSED_W'(debounce_hold_count_r) * ELAPSED_W'(HOLD_UNIT_NS);
    assign elapsed_nxt = elapsed_r + ELAPSED_W'(CLK_PERIOD_NS);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            raw_prev_r <= 1'b0;
            stable_r <= 1'b0;
            elapsed_r <= '0;
        end else begin
            raw_prev_r <= raw_trigger_in;
            if (!ctrl_r[CTRL_DEB_EN]) begin
                stable_r <= raw_trigger_in;
                elapsed_r <= '0;
            end else if (raw_trigger_in == stable_r) begin
                elapsed_r <= '0;
            end else if (raw_trigger_in != raw_prev_r) begin
                elapsed_r <= ELAPSED_W'(CLK_PERIOD_NS);
                if (ELAPSED_W'(CLK_PERIOD_NS) >= hold_ns) begin
                    stable_r <= raw_trigger_in;
                end
            end else if (elapsed_nxt >= hold_ns) begin
                stable_r <= raw_trigger_in;
                elapsed_r <= '0;
            end else begin
                elapsed_r <= elapsed_nxt;
            end
        end
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    logic [3:0] pcnt_r;
    logic pre_pulse_r;
    logic filt_rise;

    assign filt_rise = stable_r && !stable_prev_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stable_prev_r <= 1'b0;
            pcnt_r <= 4'h0;
            pre_pulse_r <= 1'b0;
        end else begin
            stable_prev_r <= stable_r;
            pre_pulse_r <= 1'b0;
            if (filt_rise) begin
                // setting n divides by n+1, so 4'hF gives 16
                if (pcnt_r == div_r) begin
                    pre_pulse_r <= 1'b1;
                    pcnt_r <= 4'h0;
                end else begin
                    pcnt_r <= pcnt_r + 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // action packet parser
    // ************************************************************
    tcf_pstate_t pstate_r;
    logic [4:0] idx_r;
    logic [31:0] shift_r;
    logic [31:0] shift_nxt;
    logic [7:0] flag_r;
    logic [15:0] req_r;
    logic [31:0] dev_r;
    logic [31:0] grp_r;
    logic hdr_ok_r;
    logic pkt_match;
    logic pkt_hit;

    assign shift_nxt = {shift_r[23:0], pkt_in.data};
    assign pkt_match = hdr_ok_r && (dev_r == device_auth_key_r) && (grp_r == group_select_key_r)
                       && ((shift_nxt & group_filter_mask_r) != 32'h0000_0000);
    assign pkt_hit = (pstate_r == PS_BODY) && pkt_in.valid && pkt_in.eop
                     && (idx_r == PKT_IDX_LAST) && pkt_match && ctrl_r[CTRL_ACT_EN];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pstate_r <= PS_IDLE;
            idx_r <= 5'd0;
            shift_r <= 32'h0000_0000;
            flag_r <= PKT_FLAG_NOACK;
            req_r <= 16'h0000;
            dev_r <= 32'h0000_0000;
            grp_r <= 32'h0000_0000;
            hdr_ok_r <= 1'b0;
        end else if (pkt_in.valid) begin
            shift_r <= shift_nxt;
            idx_r <= idx_r + 5'd1;
            if (pkt_in.sop) begin
                idx_r <= 5'd1;
                hdr_ok_r <= 1'b1;
                // unicast and broadcast go through the same check below
                if ((pkt_in.for_me || pkt_in.bcast) && (pkt_in.udp_port == PKT_UDP_PORT)
                    && (pkt_in.data == PKT_KEY) && !pkt_in.eop) begin
                    pstate_r <= PS_BODY;
                end else begin
                    pstate_r <= pkt_in.eop ? PS_IDLE : PS_DROP;
                end
            end else if (pstate_r == PS_BODY) begin
                unique case (idx_r)
                    PKT_IDX_FLAG: begin
                        flag_r <= pkt_in.data;
                        if (pkt_in.data != PKT_FLAG_ACK && pkt_in.data != PKT_FLAG_NOACK) begin
                            hdr_ok_r <= 1'b0;
                        end
                    end
                    PKT_IDX_CMD: begin
                        if (shift_nxt[15:0] != PKT_CMD_ACTION) begin
                            hdr_ok_r <= 1'b0;
                        end
                    end
                    PKT_IDX_REQ: req_r <= shift_nxt[15:0];
                    PKT_IDX_DEV: dev_r <= shift_nxt;
                    PKT_IDX_GRP: grp_r <= shift_nxt;
                    default: begin
                    end
                endcase
                // short or long frames are dropped whole
                if (pkt_in.eop || idx_r == PKT_IDX_LAST) begin
                    pstate_r <= (pkt_in.eop) ? PS_IDLE : PS_DROP;
                end
            end else if (pkt_in.eop) begin
                pstate_r <= PS_IDLE;
            end
        end
    end

    // ************************************************************
    // action release delay and acknowledge
    // ************************************************************
    logic act_pend_r;
    logic [ACT_CNT_W-1:0] act_cnt_r;
    logic act_pulse_r;
    tcf_ack_t ack_r;

    // a packet that hits while one is pending is dropped: one trigger in
    // flight keeps the release time fixed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            act_pend_r <= 1'b0;
            act_cnt_r <= '0;
            act_pulse_r <= 1'b0;
        end else begin
            act_pulse_r <= 1'b0;
            if (act_pend_r) begin
                if (act_cnt_r == ACT_CNT_W'(ACT_MIN_CYC - 2)) begin
                    act_pend_r <= 1'b0;
                    act_pulse_r <= 1'b1;
                end else begin
                    act_cnt_r <= act_cnt_r + ACT_CNT_W'(1);
                end
            end else if (pkt_hit) begin
                act_pend_r <= 1'b1;
                act_cnt_r <= '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_r <= '0;
        end else begin
            ack_r.valid <= pkt_hit && !act_pend_r && (flag_r == PKT_FLAG_ACK);
            ack_r.req_id <= req_r;
        end
    end

    // ************************************************************
    // trigger output, counter and read data
    // ************************************************************
    logic trig_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            trig_r <= 1'b0;
            trig_cnt_r <= 32'h0000_0000;
        end else begin
            trig_r <= pre_pulse_r || act_pulse_r;
            if (pre_pulse_r || act_pulse_r) begin
                trig_cnt_r <= trig_cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_go) begin
            unique case ({avs_address[4:2], 2'b00})
                REG_CTRL: rdata_r <= {30'h0, ctrl_r};
                REG_HOLD: rdata_r <= debounce_hold_count_r;
                REG_DIV: rdata_r <= {28'h0, div_r};
                REG_DEV_KEY: rdata_r <= device_auth_key_r;
                REG_GRP_KEY: rdata_r <= group_select_key_r;
                REG_GRP_MASK: rdata_r <= group_filter_mask_r;
                REG_STATUS: rdata_r <= {24'h0, pcnt_r, 1'b0, act_pend_r,
                                        stable_r, raw_prev_r};
                REG_TRIG_CNT: rdata_r <= trig_cnt_r;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign trigger_out = trig_r;
    assign ack_out = ack_r;

endmodule // tcf_trigger_filter

// File: sim/tcf_filter_asserts.sv
/*
 * tcf_filter_asserts: port-level checker for tcf_trigger_filter.
 * assumes: bound to the filter; key registers written as full words.
 */
`timescale 1ns/100ps

module tcf_filter_asserts
    import tcf_pkg::*;
#(
    parameter int HOLD_DEFAULT = HOLD_COUNT_RST
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic raw_trigger_in,
    input wire tcf_pkt_t pkt_in,
    input wire logic trigger_out,
    input wire tcf_ack_t ack_out
);
    // ************************************************************
    // helper state
    // ************************************************************
    logic [159:0] pkt_sh_r;
    logic sop_ok_r;
    logic [10:0] since_eop_r, since_ack_r;
    logic [31:0] dev_r, grp_r, mask_r;
    // partial-lane key writes are not mirrored; the bench never makes them
    wire logic bus_wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pkt_sh_r <= '0;
            sop_ok_r <= 1'b0;
        end else if (pkt_in.valid) begin
            pkt_sh_r <= {pkt_sh_r[151:0], pkt_in.data};
            if (pkt_in.sop) begin
                sop_ok_r <= (pkt_in.for_me | pkt_in.bcast) && pkt_in.udp_port == PKT_UDP_PORT;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) since_eop_r <= '0;
        else if (pkt_in.valid && pkt_in.eop) since_eop_r <= 11'h001;
        else if (since_eop_r != 11'h000 && since_eop_r != 11'h7FF) since_eop_r <= since_eop_r + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) since_ack_r <= '0;
        else if (ack_out.valid) since_ack_r <= 11'h001;
        else if (since_ack_r != 11'h000 && since_ack_r != 11'h7FF) since_ack_r <= since_ack_r + 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dev_r <= KEY_RST;
            grp_r <= KEY_RST;
            mask_r <= KEY_RST;
        end else if (bus_wr) begin
            if (avs_address[4:2] == REG_DEV_KEY[4:2]) dev_r <= avs_writedata;
            if (avs_address[4:2] == REG_GRP_KEY[4:2]) grp_r <= avs_writedata;
            if (avs_address[4:2] == REG_GRP_MASK[4:2]) mask_r <= avs_writedata;
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop the cycle after a request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_deb_stable: assert property (
        trigger_out && since_eop_r != 11'(ACT_MIN_CYC + 1) |-> $past(raw_trigger_in, 3))
        else $error("trigger without a settled raw level");
    a_trig_single: assert property (trigger_out |=> !trigger_out)
        else $error("trigger pulse longer than one cycle");
    a_ack_time: assert property (ack_out.valid |-> since_eop_r == 11'd1)
        else $error("acknowledge not one cycle after last byte");
    a_ack_fields: assert property (ack_out.valid |-> pkt_sh_r[159:152] == PKT_KEY
        && pkt_sh_r[143:128] == PKT_CMD_ACTION && ack_out.req_id == pkt_sh_r[111:96])
        else $error("acknowledge for a malformed packet");
    a_ack_flag: assert property (ack_out.valid |-> pkt_sh_r[151:144] == PKT_FLAG_ACK)
        else $error("acknowledge without a request for one");
    a_ack_keys: assert property (ack_out.valid |-> pkt_sh_r[95:64] == dev_r
        && pkt_sh_r[63:32] == grp_r && (pkt_sh_r[31:0] & mask_r) != 32'h0)
        else $error("acknowledge despite key or mask mismatch");
    a_ack_addr: assert property (ack_out.valid |-> sop_ok_r)
        else $error("acknowledge for a packet not addressed here");
    // ack is seen one cycle after the eop edge, the trigger ACT_MIN_CYC cycles after it
    a_act_delay: assert property (since_ack_r == 11'(ACT_MIN_CYC) |-> trigger_out)
        else $error("action trigger missing at the fixed delay");

    c_ack: cover property (ack_out.valid);
    c_act_trig: cover property (since_ack_r == 11'(ACT_MIN_CYC) && trigger_out);
    c_raw_trig: cover property (trigger_out && since_eop_r != 11'(ACT_MIN_CYC + 1));
endmodule // tcf_filter_asserts

// File: sim/tcf_host_model.sv
/*
 * tcf_host_model: raw trigger source and network host feeding action packets.
 * assumes: caller enters each task just after a rising edge of core_clk.
 */
`timescale 1ns/100ps

module tcf_host_model
    import tcf_pkg::*;
(
    input wire logic core_clk,
    output logic raw_trigger_in,
    output tcf_pkt_t pkt_in
);
    logic busy;

    initial begin
        raw_trigger_in = 1'b0;
        pkt_in = '0;
        busy = 1'b0;
    end

    // idle bytes keep changing so a stale byte never looks like data
    always @(posedge core_clk) begin
        if (!busy) pkt_in <= {21'h000000, ~pkt_in.data};
    end

    task automatic send_pkt(input logic [7:0] flag, input logic [31:0] dev,
        input logic [31:0] grp, input logic [31:0] mask, input logic for_me,
        input logic bcast, input logic [15:0] port, input logic [15:0] req);
        logic [159:0] body;
        body = {PKT_KEY, flag, PKT_CMD_ACTION, 16'h000C, req, dev, grp, mask};
        busy = 1'b1;
        for (int i = 0; i < 20; i++) begin
            pkt_in <= {1'b1, i == 0, i == 19, for_me, bcast, port, body[159 - 8 * i -: 8]};
            @(posedge core_clk);
        end
        pkt_in <= {21'h000000, ~body[7:0]};
        busy = 1'b0;
    endtask

    task automatic raw_pulse(input int hi, input int lo);
        raw_trigger_in <= 1'b1;
        repeat (hi) @(posedge core_clk);
        raw_trigger_in <= 1'b0;
        repeat (lo) @(posedge core_clk);
    endtask
endmodule // tcf_host_model

// File: sim/test_trigger_condition_action_filter.sv
/*
 * test_trigger_condition_action_filter: self-checking bench of the filter.
 * assumes: tcf_host_model drives raw trigger and packets; 40 MHz clock.
 */
`timescale 1ns/100ps

module test_trigger_condition_action_filter
    import tcf_pkg::*;
;
    typedef struct packed {
        logic [7:0] flag;
        logic [31:0] dev, grp, mask;
        logic for_me, bcast;
        logic [15:0] port;
        logic ack, trig;
    } tcf_row_t;

    localparam tcf_row_t ROWS [7] = '{
        '{8'h01, 32'h0000AFFE, 32'h00001234, 32'h7FFFFFFF, 1'b0, 1'b1, 16'h0F74, 1'b1, 1'b1},
        '{8'h00, 32'h0000AFFE, 32'h00001234, 32'h0000FFFF, 1'b1, 1'b0, 16'h0F74, 1'b0, 1'b1},
        '{8'h01, 32'h0000AFFE, 32'h00001234, 32'h0000000E, 1'b1, 1'b0, 16'h0F74, 1'b0, 1'b0},
        '{8'h01, 32'h0000AFFE, 32'h00000001, 32'h0000FFFF, 1'b1, 1'b0, 16'h0F74, 1'b0, 1'b0},
        '{8'h01, 32'h0000AFFF, 32'h00001234, 32'h0000FFFF, 1'b0, 1'b1, 16'h0F74, 1'b0, 1'b0},
        '{8'h01, 32'h0000AFFE, 32'h00001234, 32'h0000FFFF, 1'b1, 1'b0, 16'h0F75, 1'b0, 1'b0},
        '{8'h01, 32'h0000AFFE, 32'h00001234, 32'h0000FFFF, 1'b0, 1'b0, 16'h0F74, 1'b0, 1'b0}};
    localparam logic [31:0] RST_TAB [8] = '{32'h3, 32'h14, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    logic core_clk, reset, avs_read, avs_write, avs_waitrequest, raw_trigger_in, trigger_out;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    tcf_pkt_t pkt_in;
    tcf_ack_t ack_out;
    logic [15:0] last_req;
    int fails = 0, compares = 0, cyc = 0, trig_n = 0, ack_n = 0, base_t, base_a;

    tcf_trigger_filter #(.HOLD_DEFAULT(20)) uut (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .raw_trigger_in(raw_trigger_in),
        .pkt_in(pkt_in), .trigger_out(trigger_out), .ack_out(ack_out));
    tcf_host_model host (.core_clk(core_clk), .raw_trigger_in(raw_trigger_in), .pkt_in(pkt_in));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (trigger_out === 1'b1) trig_n <= trig_n + 1;
        if (ack_out.valid === 1'b1) begin
            ack_n <= ack_n + 1;
            last_req <= ack_out.req_id;
        end
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // only the bench timeout ends a wait that never answers
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic count_trig(input string what, input int exp, input int settle);
        repeat (settle) @(posedge core_clk);
        chk(what, 32'(exp), 32'(trig_n - base_t));
        base_t = trig_n;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            bus_xfer(1'b0, 5'(4 * i), 32'h0);
            chk("reset value", RST_TAB[i], rd);
        end
        bus_xfer(1'b1, REG_DEV_KEY, 32'h0000AFFE);
        bus_xfer(1'b1, REG_GRP_KEY, 32'h00001234);
        bus_xfer(1'b1, REG_GRP_MASK, 32'h00000001);
        for (int i = 0; i < 7; i++) begin
            base_t = trig_n;
            base_a = ack_n;
            host.send_pkt(ROWS[i].flag, ROWS[i].dev, ROWS[i].grp, ROWS[i].mask,
                ROWS[i].for_me, ROWS[i].bcast, ROWS[i].port, 16'(i));
            count_trig("action trigger", int'(ROWS[i].trig), 1040);
            chk("action ack", 32'(ROWS[i].ack), 32'(ack_n - base_a));
            if (ROWS[i].ack) chk("ack request id", 32'(i), 32'(last_req));
        end
        // hold 5 units of 15 ns needs three stable samples at 25 ns
        bus_xfer(1'b1, REG_HOLD, 32'h5);
        base_t = trig_n;
        host.raw_pulse(2, 6);
        host.raw_pulse(1, 1);
        host.raw_pulse(2, 6);
        count_trig("short or bouncing pulse", 0, 4);
        host.raw_pulse(3, 8);
        count_trig("held pulse", 1, 2);
        bus_xfer(1'b1, REG_DIV, 32'h2);
        repeat (6) host.raw_pulse(4, 4);
        count_trig("divide by three", 2, 4);
        bus_xfer(1'b1, REG_DIV, 32'hF);
        repeat (15) host.raw_pulse(4, 4);
        count_trig("fifteen of sixteen", 0, 4);
        host.raw_pulse(4, 6);
        count_trig("sixteenth pulse", 1, 2);
        bus_xfer(1'b1, REG_CTRL, 32'h2);
        bus_xfer(1'b1, REG_DIV, 32'h0);
        host.raw_pulse(1, 6);
        count_trig("debounce bypassed", 1, 2);
        bus_xfer(1'b1, REG_TRIG_CNT, 32'h0);
        bus_xfer(1'b0, REG_TRIG_CNT, 32'h0);
        chk("trigger count", 32'h7, rd);
        stop_test();
    end
endmodule // test_trigger_condition_action_filter

bind tcf_trigger_filter tcf_filter_asserts #(.HOLD_DEFAULT(HOLD_DEFAULT)) chk_i (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .raw_trigger_in(raw_trigger_in), .pkt_in(pkt_in), .trigger_out(trigger_out),
    .ack_out(ack_out));
